// File: pkg/lhs_cfg.svh
`ifndef LHS_CFG_SVH
`define LHS_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define LHS_ADR_CTL 8'h30
`define LHS_ADR_DIV 8'h34
`define LHS_ADR_STS 8'h38
`define LHS_ADR_ISR 8'h3c
`define LHS_ADR_IMR 8'h40

// ****************************************
// Field positions
// ****************************************
`define LHS_CTL_RESP 0
`define LHS_CTL_HDR 1
`define LHS_CTL_PAR 9
`define LHS_CTL_AUTO 11
`define LHS_STS_DET 0
`define LHS_STS_HE 1
`define LHS_STS_PE 2

// ****************************************
// Reset values and timing
// ****************************************
`define LHS_STS_RST 3'h0
`define LHS_DIV_RST 16'h196e
`define LHS_SYNC_PATTERN 8'h55
`define LHS_BREAK_BITS 11
`define LHS_HDR_BITS 48
`define LHS_SYNC_BITS 8
`define LHS_SYNC_FALLS 3'h4

`endif

// File: pkg/lhs_pkg.sv
package lhs_pkg;
    // Gray coded along idle, break, delimiter, sync, gap, identifier
    typedef enum logic [2:0] {
        LHS_IDLE = 3'h0,
        LHS_BRK = 3'h1,
        LHS_DELIM = 3'h3,
        LHS_SYNC = 3'h2,
        LHS_GAP = 3'h6,
        LHS_PID = 3'h7
    } lhs_state_t;
endpackage

// File: core/lhs_status.sv
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "lhs_cfg.svh"
// Contract
// RULE1 - Header receiver runs only while responder mode enable is set.
// RULE2 - Identifier parity mismatch sets the parity-error flag; otherwise it reads zero.
// RULE3 - Parity-error flag acts only with responder mode and parity check enabled.
// RULE4 - Writing one clears a flag; writing zero leaves it unchanged.
// RULE5 - Any header error in responder mode sets the sticky header-error flag; the code sets it only when header detection (ctl_hdr) is also enabled.
// RULE6 - Break delimiter shorter than half a bit is a header error.
// RULE7 - Missing stop bit in sync or identifier byte is a header error.
// RULE8 - Without auto resync, sync byte other than pattern is a header error.
// RULE9 - With auto resync, excessive sync baud deviation is a header error.
// RULE10 - With auto resync, sync measurement timeout is a header error.
// RULE11 - Header not complete within reception limit is a header error.
// RULE12 - Header flags act only with responder mode and header detection enabled.
// RULE13 - Complete break, sync and identifier sets the header-detected flag.
// RULE14 - Header-detected flag sets even when identifier parity is wrong.
// RULE15 - Flags reset to zero and never set while their enables are off.
module lhs_status
    import lhs_pkg::*;
#(
    parameter int CNT_W = 24
) (
    input wire logic clk_i, // 125 MHz clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic rxd_i, // LIN receive line
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [3:0] wb_sel_i, // Byte lanes
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    output logic irq_o // Level interrupt
);

    // ****************************************
    // Declarations
    // ****************************************
    logic ctl_resp, ctl_hdr, ctl_par, ctl_auto;
    logic next_ctl_resp, next_ctl_hdr, next_ctl_par, next_ctl_auto;
    logic [15:0] div_q, next_div_q;
    logic [2:0] flags, next_flags, isr, next_isr, imr, next_imr;
    logic [31:0] next_dat;
    logic next_ack, next_irq;
    lhs_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt, hdr_cnt, next_hdr_cnt, meas, next_meas;
    logic [3:0] bitpos, next_bitpos;
    logic [7:0] shreg, next_shreg;
    logic [2:0] falls, next_falls;
    logic meas_ok, next_meas_ok, rx_q, rx_p;
    logic ev_he, ev_det, ev_pe, set_he, set_det, set_pe;
    logic [2:0] sets;
    logic commit, wr, rd, fall, tick, dev_bad;
    logic [CNT_W-1:0] div_w, half_w, brk_lim, hdr_lim, meas_nom;

    function automatic logic parity_bad(input logic [7:0] pid);
        logic p0, p1;
        p0 = pid[0] ^ pid[1] ^ pid[2] ^ pid[4];
        p1 = ~(pid[1] ^ pid[3] ^ pid[4] ^ pid[5]);
        return (p0 != pid[6]) || (p1 != pid[7]);
    endfunction

    function automatic logic [CNT_W-1:0] bits_to_cyc(input logic [15:0] d, input int n);
        return CNT_W'(32'(d) * n);
    endfunction

    assign div_w = CNT_W'(div_q);
    assign half_w = div_w >> 1;
    assign brk_lim = bits_to_cyc(div_q, `LHS_BREAK_BITS);
    assign hdr_lim = bits_to_cyc(div_q, `LHS_HDR_BITS);
    assign meas_nom = bits_to_cyc(div_q, `LHS_SYNC_BITS);
    assign fall = rx_p & ~rx_q;
    assign tick = (cnt == div_w - CNT_W'(1));
    assign dev_bad = (meas > meas_nom + div_w) || (meas + div_w < meas_nom);

    // ****************************************
    // Header receiver
    // ****************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt + CNT_W'(1);
        next_hdr_cnt = hdr_cnt;
        next_bitpos = bitpos;
        next_shreg = shreg;
        next_meas = meas;
        next_falls = falls;
        next_meas_ok = meas_ok;
        ev_he = 1'b0;
        ev_det = 1'b0;
        ev_pe = 1'b0;
        case (state)
            LHS_IDLE: begin
                next_cnt = '0;
                next_hdr_cnt = '0;
                if (fall) begin
                    next_state = LHS_BRK;
                end
            end
            LHS_BRK: begin
                // A short low is an ordinary character, not a header error
                if (rx_q) begin
                    next_cnt = '0;
                    next_state = (cnt >= brk_lim) ? LHS_DELIM : LHS_IDLE;
                end
            end
            LHS_DELIM, LHS_GAP: begin
                if (fall && state == LHS_DELIM && cnt < half_w) begin
                    ev_he = 1'b1; // see RULE6
                    next_state = LHS_IDLE;
                end else if (fall) begin
                    next_state = (state == LHS_DELIM) ? LHS_SYNC : LHS_PID;
                    next_cnt = half_w;
                    next_bitpos = 4'h0;
                    next_meas = '0;
                    next_falls = 3'h0;
                    next_meas_ok = 1'b0;
                end
            end
            LHS_SYNC, LHS_PID: begin
                if (state == LHS_SYNC && !meas_ok) begin
                    // Start edge to fifth falling edge spans eight bit times
                    next_meas = meas + CNT_W'(1);
                    if (fall) begin
                        next_falls = falls + 3'h1;
                        next_meas_ok = (falls + 3'h1 == `LHS_SYNC_FALLS);
                        next_meas = meas;
                    end
                    if (ctl_auto && meas >= (meas_nom << 1)) begin
                        ev_he = 1'b1; // see RULE10
                        next_state = LHS_IDLE;
                    end
                end
                if (tick && next_state != LHS_IDLE) begin
                    next_cnt = '0;
                    next_bitpos = bitpos + 4'h1;
                    if (bitpos >= 4'h1 && bitpos <= 4'h8) begin
                        next_shreg = {rx_q, shreg[7:1]};
                    end
                    if (bitpos == 4'h9 && state == LHS_SYNC && ctl_auto && !meas_ok) begin
                        // Stop sample waits for the measurement or its timeout
                        next_bitpos = bitpos;
                    end else if (bitpos == 4'h9) begin
                        next_state = LHS_IDLE;
                        if (!rx_q) begin
                            ev_he = 1'b1; // see RULE7
                        end else if (state == LHS_PID) begin
                            ev_det = 1'b1; // see RULE13, RULE14
                            ev_pe = parity_bad(shreg); // see RULE2
                        end else if (!ctl_auto && shreg != `LHS_SYNC_PATTERN) begin
                            ev_he = 1'b1; // see RULE8
                        end else if (ctl_auto && dev_bad) begin
                            ev_he = 1'b1; // see RULE9
                        end else begin
                            next_state = LHS_GAP;
                        end
                    end
                end
            end
            default: begin
                next_state = LHS_IDLE;
            end
        endcase
        if (state != LHS_IDLE) begin
            next_hdr_cnt = hdr_cnt + CNT_W'(1);
            if (hdr_cnt >= hdr_lim && !ev_det) begin
                ev_he = 1'b1; // see RULE11
                next_state = LHS_IDLE;
            end
        end
        if (!ctl_resp) begin
            next_state = LHS_IDLE; // see RULE1
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= LHS_IDLE;
            cnt <= '0;
            hdr_cnt <= '0;
            bitpos <= 4'h0;
            shreg <= 8'h00;
            meas <= '0;
            falls <= 3'h0;
            meas_ok <= 1'b0;
            rx_q <= 1'b1;
            rx_p <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            hdr_cnt <= next_hdr_cnt;
            bitpos <= next_bitpos;
            shreg <= next_shreg;
            meas <= next_meas;
            falls <= next_falls;
            meas_ok <= next_meas_ok;
            rx_q <= rxd_i;
            rx_p <= rx_q;
        end
    end

    // ****************************************
    // Flags, interrupts and bus slave
    // ****************************************
    assign set_he = ev_he & ctl_resp & ctl_hdr; // see RULE5, RULE12, RULE15
    assign set_det = ev_det & ctl_resp & ctl_hdr; // see RULE12, RULE15
    assign set_pe = ev_pe & ctl_resp & ctl_par; // see RULE3, RULE15
    assign sets = {set_pe, set_he, set_det};
    // Writes and read clears land on the edge where the master sees ack
    assign commit = wb_cyc_i & wb_stb_i & wb_ack_o;
    assign wr = commit & wb_we_i;
    assign rd = commit & ~wb_we_i;

    always_comb begin
        next_ctl_resp = ctl_resp;
        next_ctl_hdr = ctl_hdr;
        next_ctl_par = ctl_par;
        next_ctl_auto = ctl_auto;
        next_div_q = div_q;
        next_imr = imr;
        next_flags = flags;
        next_isr = isr;
        if (wr && wb_adr_i == `LHS_ADR_CTL) begin
            if (wb_sel_i[0]) begin
                next_ctl_resp = wb_dat_i[`LHS_CTL_RESP];
                next_ctl_hdr = wb_dat_i[`LHS_CTL_HDR];
            end
            if (wb_sel_i[1]) begin
                next_ctl_par = wb_dat_i[`LHS_CTL_PAR];
                next_ctl_auto = wb_dat_i[`LHS_CTL_AUTO];
            end
        end
        if (wr && wb_adr_i == `LHS_ADR_DIV) begin
            if (wb_sel_i[0]) next_div_q[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) next_div_q[15:8] = wb_dat_i[15:8];
        end
        if (wr && wb_adr_i == `LHS_ADR_IMR && wb_sel_i[0]) begin
            next_imr = wb_dat_i[2:0];
        end
        if (wr && wb_adr_i == `LHS_ADR_STS && wb_sel_i[0]) begin
            next_flags = flags & ~wb_dat_i[2:0]; // see RULE4
        end
        if (rd && wb_adr_i == `LHS_ADR_ISR) begin
            next_isr = 3'h0;
        end
        // A set in the clearing cycle wins
        next_flags = next_flags | sets;
        next_isr = next_isr | sets;
        next_irq = |(next_isr & next_imr);
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        case (wb_adr_i)
            `LHS_ADR_CTL: next_dat = 32'(ctl_resp) << `LHS_CTL_RESP | 32'(ctl_hdr) << `LHS_CTL_HDR
                | 32'(ctl_par) << `LHS_CTL_PAR | 32'(ctl_auto) << `LHS_CTL_AUTO;
            `LHS_ADR_DIV: next_dat = {16'h0000, div_q};
            `LHS_ADR_STS: next_dat = {29'h0, flags};
            `LHS_ADR_ISR: next_dat = {29'h0, isr};
            `LHS_ADR_IMR: next_dat = {29'h0, imr};
            default: next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_resp <= 1'b0;
            ctl_hdr <= 1'b0;
            ctl_par <= 1'b0;
            ctl_auto <= 1'b0;
            div_q <= `LHS_DIV_RST;
            imr <= 3'h0;
            flags <= `LHS_STS_RST;
            isr <= 3'h0;
            irq_o <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ctl_resp <= next_ctl_resp;
            ctl_hdr <= next_ctl_hdr;
            ctl_par <= next_ctl_par;
            ctl_auto <= next_ctl_auto;
            div_q <= next_div_q;
            imr <= next_imr;
            flags <= next_flags;
            isr <= next_isr;
            irq_o <= next_irq;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    resp_off_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
        !ctl_resp |=> state == LHS_IDLE) else $error("receiver active while responder off");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE4
        wr && wb_adr_i == `LHS_ADR_STS && wb_sel_i[0] && wb_dat_i[1] && !set_he
        |=> !flags[`LHS_STS_HE]) else $error("header error flag not cleared");
    write_zero_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE4
        flags[`LHS_STS_DET] && wr && !wb_dat_i[0] |=> flags[`LHS_STS_DET])
        else $error("flag lost on write of zero");
    pe_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE3
        $rose(flags[`LHS_STS_PE]) |-> $past(ctl_resp) && $past(ctl_par))
        else $error("parity flag set while disabled");
    he_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE12
        $rose(flags[`LHS_STS_HE]) |-> $past(ctl_resp) && $past(ctl_hdr))
        else $error("header error flag set while disabled");
    det_parity_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE14
        ev_det && ev_pe && ctl_resp && ctl_hdr && ctl_par
        |=> flags[`LHS_STS_DET] && flags[`LHS_STS_PE]) else $error("detect lost on bad parity");
    sync_pattern_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE8
        state == LHS_SYNC && tick && bitpos == 4'h9 && rx_q && !ctl_auto
        && shreg != `LHS_SYNC_PATTERN && ctl_resp && ctl_hdr
        |=> flags[`LHS_STS_HE] && state == LHS_IDLE) else $error("bad sync not flagged");
    frame_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE7
        (state == LHS_SYNC || state == LHS_PID) && tick && bitpos == 4'h9 && !rx_q
        && !(state == LHS_SYNC && ctl_auto && !meas_ok)
        |=> state == LHS_IDLE ##0 !(ctl_resp && ctl_hdr) || flags[`LHS_STS_HE])
        else $error("framing error not flagged");
    reset_flags_a: assert property (@(posedge clk_i) // see RULE15
        rst_i |=> flags == 3'h0 && !irq_o) else $error("flags not zero after reset");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule

// File: dv/lhs_commander.sv
`timescale 1ns/10ps
// ****************************************
// LIN commander sending frame headers
// ****************************************
module lhs_commander (
    input wire logic clk_i, // Bench clock
    output logic rxd_o // Line towards the responder
);
    int bit_clks = 8;
    initial rxd_o = 1'b1;
    task automatic hold(input logic lvl, input int clks);
        rxd_o <= lvl;
        repeat (clks) @(posedge clk_i);
    endtask
    // Bit time of one byte can be stretched to skew the sync measurement
    task automatic send_byte(input logic [7:0] b, input int bt, input logic stp);
        hold(1'b0, bt);
        for (int i = 0; i < 8; i++) begin
            hold(b[i], bt);
        end
        hold(stp, bt);
    endtask
    task automatic send_header(input int dlm, input logic [7:0] syn, input int sbt,
                               input logic sst, input int gap, input logic [7:0] pid);
        hold(1'b0, 13 * bit_clks);
        hold(1'b1, dlm);
        send_byte(syn, sbt, sst);
        hold(1'b1, gap * bit_clks);
        send_byte(pid, bit_clks, 1'b1);
        // Idle line rests high between headers
        hold(1'b1, 16 * bit_clks);
    endtask
endmodule

// File: dv/lin_slave_header_status_bench.sv
`timescale 1ns/10ps
`include "lhs_cfg.svh"
module lin_slave_header_status_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rxd;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [3:0] lanes = 4'hf;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    logic [31:0] q;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] good_pid;
    always #4 clk_i = ~clk_i;
    lhs_status u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .rxd_i(rxd), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o)
    );
    lhs_commander u_cmd (.clk_i(clk_i), .rxd_o(rxd));
    // ****************************************
    // Access and compare helpers
    // ****************************************
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        // Whole run needs about 6700 cycles
        if (cycles == 40000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= lanes;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_sel <= 4'h0;
        @(posedge clk_i);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(name, q & m, e);
    endtask
    // Program control, send one header, leave flags for the caller
    task automatic hdr(input logic [31:0] ctl, input int dlm, input logic [7:0] syn,
                       input int sbt, input logic sst, input int gap, input logic [7:0] pid);
        wb(1'b1, `LHS_ADR_STS, 32'h7);
        wb(1'b1, `LHS_ADR_CTL, ctl);
        u_cmd.send_header(dlm, syn, sbt, sst, gap, pid);
    endtask
    function automatic logic [7:0] pid_of(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        good_pid = pid_of(6'h12);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("ctl", `LHS_ADR_CTL, 32'hffffffff, 32'h0);
        rd_chk("div", `LHS_ADR_DIV, 32'hffffffff, 32'h196e);
        rd_chk("sts", `LHS_ADR_STS, 32'hffffffff, 32'h0);
        rd_chk("unmapped", 8'h44, 32'hffffffff, 32'h0);
        check("irq", {31'h0, irq_o}, 32'h0);
        wb(1'b1, `LHS_ADR_DIV, 32'h8);
        hdr(32'h0, 8, 8'h55, 8, 1'b1, 1, good_pid);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h0);
        hdr(32'h1, 8, 8'h55, 8, 1'b1, 1, good_pid);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h0);
        hdr(32'h1, 2, 8'h55, 8, 1'b1, 1, good_pid);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h0);
        hdr(32'h3, 8, 8'h55, 8, 1'b1, 1, good_pid ^ 8'h40);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h1);
        hdr(32'h203, 8, 8'h55, 8, 1'b1, 1, good_pid);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h1);
        wb(1'b1, `LHS_ADR_STS, 32'h0);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h1);
        // Low byte lane off, so the clear must not land
        lanes = 4'he;
        wb(1'b1, `LHS_ADR_STS, 32'h1);
        lanes = 4'hf;
        rd_chk("sts lane", `LHS_ADR_STS, 32'h7, 32'h1);
        wb(1'b1, `LHS_ADR_STS, 32'h1);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h0);
        hdr(32'h203, 8, 8'h55, 8, 1'b1, 1, good_pid ^ 8'h80);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h5);
        // Interrupt raised, cleared by read, then masked
        wb(1'b0, `LHS_ADR_ISR, 32'h0);
        wb(1'b1, `LHS_ADR_IMR, 32'h1);
        hdr(32'h203, 8, 8'h55, 8, 1'b1, 1, good_pid);
        check("irq", {31'h0, irq_o}, 32'h1);
        rd_chk("isr", `LHS_ADR_ISR, 32'h7, 32'h1);
        @(posedge clk_i);
        check("irq", {31'h0, irq_o}, 32'h0);
        wb(1'b1, `LHS_ADR_IMR, 32'h2);
        rd_chk("imr", `LHS_ADR_IMR, 32'hffffffff, 32'h2);
        hdr(32'h3, 8, 8'h55, 8, 1'b1, 1, good_pid);
        check("irq masked", {31'h0, irq_o}, 32'h0);
        rd_chk("isr", `LHS_ADR_ISR, 32'h7, 32'h1);
        // Header error cases, error flag only, then a clean header with auto resync
        hdr(32'h3, 2, 8'h55, 8, 1'b1, 1, good_pid);
        rd_chk("he", `LHS_ADR_STS, 32'h2, 32'h2);
        hdr(32'h3, 8, 8'h55, 8, 1'b0, 1, good_pid);
        rd_chk("he", `LHS_ADR_STS, 32'h2, 32'h2);
        hdr(32'h3, 8, 8'h54, 8, 1'b1, 1, good_pid);
        rd_chk("he", `LHS_ADR_STS, 32'h2, 32'h2);
        hdr(32'h803, 8, 8'h55, 8, 1'b1, 1, good_pid);
        rd_chk("sts", `LHS_ADR_STS, 32'h7, 32'h1);
        rd_chk("ctl", `LHS_ADR_CTL, 32'hffffffff, 32'h803);
        // Fast sync bits measure short and trip the deviation check
        hdr(32'h803, 8, 8'h55, 7, 1'b1, 1, good_pid);
        rd_chk("he", `LHS_ADR_STS, 32'h2, 32'h2);
        hdr(32'h803, 8, 8'h55, 20, 1'b1, 1, good_pid);
        rd_chk("he", `LHS_ADR_STS, 32'h2, 32'h2);
        hdr(32'h3, 8, 8'h55, 8, 1'b1, 40, good_pid);
        rd_chk("he", `LHS_ADR_STS, 32'h2, 32'h2);
        test_done();
    end
endmodule
